// *** pdt_params.svh ***
`ifndef PDT_PARAMS_SVH
`define PDT_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define PDT_CNT_W      16
`define PDT_ADDR_W     4
`define PDT_CNT_MAX    16'hffff

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain port)
// ----------------------------------------------------------------
`define PDT_OFF_C0     4'h0
`define PDT_OFF_C1     4'h1
`define PDT_OFF_C2     4'h2
`define PDT_OFF_DL     4'h3
`define PDT_OFF_DH     4'h4
`define PDT_OFF_AL     4'h5
`define PDT_OFF_AH     4'h6
`define PDT_OFF_BL     4'h7
`define PDT_OFF_BH     4'h8
`define PDT_OFF_PL     4'h9
`define PDT_OFF_PH     4'ha

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define PDT_RST_CTRL   8'h00
`define PDT_RST_WORD   16'h0000
`define PDT_MASK_C0    8'hf8
`define PDT_MASK_C2    8'h06

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PDT_C0_PAU     7
`define PDT_C0_CK_HI   6
`define PDT_C0_CK_LO   4
`define PDT_C0_ON      3
`define PDT_C1_M_HI    7
`define PDT_C1_M_LO    6
`define PDT_C1_IO_HI   5
`define PDT_C1_IO_LO   4
`define PDT_C1_OC      3
`define PDT_C1_POL     2
`define PDT_C1_CAPTS   1
`define PDT_C1_CCLR    0
`define PDT_C2_TC_HI   2
`define PDT_C2_TC_LO   1
`define PDT_C2_VLF     0

// ----------------------------------------------------------------
// Prescaler terminal counts
// ----------------------------------------------------------------
`define PDT_DIV4_LAST  2'h3
`define PDT_DIV16_LAST 4'hf
`define PDT_DIV64_LAST 6'h3f

`endif

// *** pdt_pkg.sv ***
`include "pdt_params.svh"

package pdt_pkg;

  // Register port request
  typedef struct packed {
    logic [`PDT_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr;
    logic                   rd;
  } pdt_bus_req_t;

  // Pins and foreign clocks, all asynchronous to mclk
  typedef struct packed {
    logic lsClk;
    logic hsClk;
    logic capIn;
    logic extClk;
  } pdt_pins_t;

  // Operating modes
  typedef enum logic [1:0] {
    PDT_M_CMP = 2'b00,
    PDT_M_CAP = 2'b01,
    PDT_M_PWM = 2'b10,
    PDT_M_TMR = 2'b11
  } pdt_mode_t;

  // Whole state of the timer
  typedef struct packed {
    logic [7:0]                 c0;
    logic [7:0]                 c1;
    logic [7:0]                 c2;
    logic [`PDT_CNT_W-1:0]      cnt;
    logic [`PDT_CNT_W-1:0]      cmpA;
    logic [`PDT_CNT_W-1:0]      cmpB;
    logic [`PDT_CNT_W-1:0]      cmpP;
    logic [3:0][2:0]            sy;
    logic [1:0]                 mainDiv;
    logic [5:0]                 hsDiv;
    logic                       onPrev;
    logic                       outLvl;
    logic                       pulseDone;
    logic                       outPin;
    logic                       outPinN;
    logic                       evtA;
    logic                       evtP;
    logic [7:0]                 rdData;
  } pdt_state_t;

endpackage

// *** pdt_timer.sv ***
`include "pdt_params.svh"

module pdt_timer (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire pdt_pkg::pdt_bus_req_t busReq,
  output logic [7:0]             rdData,
  input  wire pdt_pkg::pdt_pins_t pinsIn,
  output logic                   timerOutputPin,
  output logic                   timerOutputInvertedPin,
  output logic                   matchAEvt,
  output logic                   matchPEvt
);
  import pdt_pkg::*;

  // ----------------------------------------------------------------
  // State and decoded controls
  // ----------------------------------------------------------------
  pdt_state_t            s_r;       // Registered state
  pdt_state_t            s_nxt;     // Next state
  logic [3:0]            pinV;      // Raw pin vector
  logic [3:0]            rise;      // Synced rising edges
  logic [3:0]            fall;      // Synced falling edges
  pdt_mode_t             mode;      // Operating mode
  logic [1:0]            io;        // Pin function field
  logic [2:0]            ckSel;     // Clock select field
  logic [1:0]            tClr;      // Capture clear field
  logic                  on;        // Timer on
  logic                  pause;     // Counter pause
  logic                  oc;        // Initial or active level
  logic                  pol;       // Output invert
  logic                  cclr;      // Clear source select
  logic                  tick;      // Counter clock enable
  logic                  run;       // Counter advances now
  logic                  onRise;    // Timer on went 0 to 1
  logic                  hitA;      // Comparator A match
  logic                  hitP;      // Comparator P match
  logic                  ovf;       // Counter at all ones
  logic                  capR;      // Capture rising edge
  logic                  capF;      // Capture falling edge
  logic                  capEn;     // Capture mode active
  logic                  capClr;    // Edge clear in capture
  logic                  clr;       // Counter clear on tick
  logic                  pwmLvl;    // PWM waveform level

  // Pins into one vector, index matches struct order
  assign pinV = {pinsIn.lsClk, pinsIn.hsClk, pinsIn.capIn, pinsIn.extClk};

  // ----------------------------------------------------------------
  // Edge detection per synchronised pin
  // ----------------------------------------------------------------
  // One detector per pin, all four alike
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_edge
      // Stage 1 of the synced pair vs the last level held in stage 2
      assign rise[g] = s_r.sy[g][1] & ~s_r.sy[g][2];
      assign fall[g] = ~s_r.sy[g][1] & s_r.sy[g][2];
    end
  endgenerate

  // Field decode
  // Fields come straight from the held registers
  assign pause = s_r.c0[`PDT_C0_PAU];
  assign ckSel = s_r.c0[`PDT_C0_CK_HI:`PDT_C0_CK_LO];
  assign on    = s_r.c0[`PDT_C0_ON];
  assign mode  = pdt_mode_t'(s_r.c1[`PDT_C1_M_HI:`PDT_C1_M_LO]);
  assign io    = s_r.c1[`PDT_C1_IO_HI:`PDT_C1_IO_LO];
  assign oc    = s_r.c1[`PDT_C1_OC];
  assign pol   = s_r.c1[`PDT_C1_POL];
  assign cclr  = s_r.c1[`PDT_C1_CCLR];
  assign tClr  = s_r.c2[`PDT_C2_TC_HI:`PDT_C2_TC_LO];

  // ----------------------------------------------------------------
  // Counter clock selection
  // ----------------------------------------------------------------
  // One counting step per tick; dividers free-run
  // Foreign clocks count on their synced rising edge
  always_comb begin
    case (ckSel)
      3'b000:  tick = (s_r.mainDiv == `PDT_DIV4_LAST);
      3'b001:  tick = 1'b1;
      3'b010:  tick = rise[2] & (s_r.hsDiv[3:0] == `PDT_DIV16_LAST);
      3'b011:  tick = rise[2] & (s_r.hsDiv == `PDT_DIV64_LAST);
      3'b100:  tick = rise[3];
      3'b101:  tick = rise[3];
      3'b110:  tick = rise[0];
      default: tick = fall[0];
    endcase
  end

  // ----------------------------------------------------------------
  // Match, clear and capture conditions
  // ----------------------------------------------------------------
  always_comb begin
    // Advance only when on and not paused
    // On-rise cycle only zeroes, so stale counts never match
    run    = on & s_r.onPrev & ~pause & tick;
    onRise = on & ~s_r.onPrev;
    // Full-width compares; zero value means no match
    hitA   = run & (s_r.cnt == s_r.cmpA) & (s_r.cmpA != `PDT_RST_WORD);
    hitP   = run & (s_r.cnt == s_r.cmpP) & (s_r.cmpP != `PDT_RST_WORD);
    ovf    = run & (s_r.cnt == `PDT_CNT_MAX);
    // Capture source and edges
    // Source is the capture pin or the clock pin
    capEn  = on & (mode == PDT_M_CAP);
    capR   = capEn & (s_r.c1[`PDT_C1_CAPTS] ? rise[0] : rise[1]);
    capF   = capEn & (s_r.c1[`PDT_C1_CAPTS] ? fall[0] : fall[1]);
    // Edge clears in capture mode
    // Codes 01, 10, 11: rise, fall, both
    case (tClr)
      2'b01:   capClr = capR;
      2'b10:   capClr = capF;
      2'b11:   capClr = capR | capF;
      default: capClr = 1'b0;
    endcase
    // Clear on tick per mode
    // Capture and waveform modes clear on P
    case (mode)
      PDT_M_CMP: clr = cclr ? hitA : hitP;
      PDT_M_TMR: clr = cclr ? hitA : hitP;
      default:   clr = hitP;
    endcase
    // PWM level: active while below A, 100% when A > P, P nonzero
    // Duty above a nonzero period keeps it active
    pwmLvl = (s_r.cnt < s_r.cmpA) ? oc : ~oc;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Start from held state; pulses and read data default low
  always_comb begin
    s_nxt        = s_r;
    s_nxt.evtA   = 1'b0;
    s_nxt.evtP   = 1'b0;
    s_nxt.rdData = 8'h00;
    s_nxt.onPrev = on;

    // Two-flop synchronisers plus edge history
    // Bits 0 and 1 synchronise, bit 2 keeps last level
    for (int i = 0; i < 4; i++) begin
      s_nxt.sy[i] = {s_r.sy[i][1], s_r.sy[i][0], pinV[i]};
    end

    // Prescalers for main and high-speed clocks
    // Both run even while the timer is off
    s_nxt.mainDiv = s_r.mainDiv + 2'h1;
    if (rise[2]) begin
      s_nxt.hsDiv = s_r.hsDiv + 6'h01;
    end

    // Counter: no software load path, wrap at all ones
    if (onRise) begin
      // Switching on restarts from zero
      s_nxt.cnt = `PDT_RST_WORD;
    end else if (capClr) begin
      // Selected capture edge clears
      s_nxt.cnt = `PDT_RST_WORD;
    end else if (run) begin
      if (clr) begin
        // Selected match ends the period
        s_nxt.cnt = `PDT_RST_WORD;
      end else begin
        // Plain step; all ones wraps
        s_nxt.cnt = s_r.cnt + 16'h0001;
      end
    end

    // Match events; P flag suppressed when A clears
    // With P at zero the wrap stands in for P in compare and timer modes
    s_nxt.evtA = hitA;
    if ((mode == PDT_M_CMP) || (mode == PDT_M_TMR)) begin
      if (!cclr) begin
        s_nxt.evtP = hitP | (ovf & (s_r.cmpP == `PDT_RST_WORD));
      end
    end else begin
      // Other modes flag every P match
      s_nxt.evtP = hitP;
    end

    // Output level
    // On-rise restores the initial level first in compare and PWM modes
    if (onRise && (mode != PDT_M_TMR) && (mode != PDT_M_CAP)) begin
      s_nxt.outLvl    = oc;
      s_nxt.pulseDone = 1'b0;
    end else begin
      case (mode)
        PDT_M_CMP: begin
          // Only A match acts; same level means no change
          // P match never moves the pin
          if (hitA) begin
            case (io)
              2'b01:   s_nxt.outLvl = 1'b0;
              2'b10:   s_nxt.outLvl = 1'b1;
              2'b11:   s_nxt.outLvl = ~s_r.outLvl;
              default: s_nxt.outLvl = s_r.outLvl;
            endcase
          end
        end
        PDT_M_PWM: begin
          // Forced levels, waveform or one pulse
          // Waveform keeps running under forced levels
          case (io)
            2'b00:   s_nxt.outLvl = ~oc;
            2'b01:   s_nxt.outLvl = oc;
            2'b10:   s_nxt.outLvl = pwmLvl;
            default: begin
              // Single pulse ends at the first A match
              if (hitA) begin
                s_nxt.pulseDone = 1'b1;
              end
              s_nxt.outLvl = (on & ~s_nxt.pulseDone) ? oc : ~oc;
            end
          endcase
        end
        default: begin
          // Timer and capture modes leave the level alone
          s_nxt.outLvl = s_r.outLvl;
        end
      endcase
    end

    // Pin drive with optional inversion
    // Timer mode freezes both pins
    // Companion is the complement; reset zeroes both
    if (mode == PDT_M_TMR) begin
      s_nxt.outPin  = s_r.outPin;
      s_nxt.outPinN = s_r.outPinN;
    end else begin
      s_nxt.outPin  = s_nxt.outLvl ^ pol;
      s_nxt.outPinN = ~(s_nxt.outLvl ^ pol);
    end

    // Register writes
    // Counter bytes have no write path
    if (busReq.wr) begin
      if (busReq.addr == `PDT_OFF_C0) begin
        // Low three bits stay zero
        s_nxt.c0 = busReq.wdata & `PDT_MASK_C0;
      end else if (busReq.addr == `PDT_OFF_C1) begin
        // Mode and pin control
        s_nxt.c1 = busReq.wdata;
      end else if (busReq.addr == `PDT_OFF_C2) begin
        // Clear select only; flag kept
        s_nxt.c2 = (s_r.c2 & ~`PDT_MASK_C2) | (busReq.wdata & `PDT_MASK_C2);
      end else if (busReq.addr == `PDT_OFF_AL) begin
        // A low byte
        s_nxt.cmpA[7:0] = busReq.wdata;
      end else if (busReq.addr == `PDT_OFF_AH) begin
        // A high byte
        s_nxt.cmpA[15:8] = busReq.wdata;
      end else if (busReq.addr == `PDT_OFF_BL) begin
        // B low byte
        s_nxt.cmpB[7:0] = busReq.wdata;
      end else if (busReq.addr == `PDT_OFF_BH) begin
        // B high byte
        s_nxt.cmpB[15:8] = busReq.wdata;
      end else if (busReq.addr == `PDT_OFF_PL) begin
        // P low byte
        s_nxt.cmpP[7:0] = busReq.wdata;
      end else if (busReq.addr == `PDT_OFF_PH) begin
        // P high byte
        s_nxt.cmpP[15:8] = busReq.wdata;
      end
    end

    // Capture latches win over a same-cycle write
    // Edges only count while capture mode runs
    if (tClr == 2'b00) begin
      // All captures go to A
      if ((capR && (io == 2'b00 || io == 2'b10)) || (capF && (io == 2'b01 || io == 2'b10))) begin
        s_nxt.cmpA = s_r.cnt;
      end
    end else begin
      // Rising edges to B, falling edges to A
      // Flag tells which edge latched last
      if (capR && (io == 2'b00 || io == 2'b10)) begin
        s_nxt.cmpB = s_r.cnt;
        s_nxt.c2[`PDT_C2_VLF] = 1'b1;
      end else if (capF && (io == 2'b01 || io == 2'b10)) begin
        s_nxt.cmpA = s_r.cnt;
        s_nxt.c2[`PDT_C2_VLF] = 1'b0;
      end
    end

    // Register reads, data valid next cycle only
    // Unimplemented bits are zero in the stored copy
    if (busReq.rd) begin
      if (busReq.addr == `PDT_OFF_C0) begin
        // Control 0
        s_nxt.rdData = s_r.c0;
      end else if (busReq.addr == `PDT_OFF_C1) begin
        // Control 1
        s_nxt.rdData = s_r.c1;
      end else if (busReq.addr == `PDT_OFF_C2) begin
        // Capture control
        s_nxt.rdData = s_r.c2;
      end else if (busReq.addr == `PDT_OFF_DL) begin
        // Live count, low
        s_nxt.rdData = s_r.cnt[7:0];
      end else if (busReq.addr == `PDT_OFF_DH) begin
        // Live count, high
        s_nxt.rdData = s_r.cnt[15:8];
      end else if (busReq.addr == `PDT_OFF_AL) begin
        // A low byte
        s_nxt.rdData = s_r.cmpA[7:0];
      end else if (busReq.addr == `PDT_OFF_AH) begin
        // A high byte
        s_nxt.rdData = s_r.cmpA[15:8];
      end else if (busReq.addr == `PDT_OFF_BL) begin
        // B low byte
        s_nxt.rdData = s_r.cmpB[7:0];
      end else if (busReq.addr == `PDT_OFF_BH) begin
        // B high byte
        s_nxt.rdData = s_r.cmpB[15:8];
      end else if (busReq.addr == `PDT_OFF_PL) begin
        // P low byte
        s_nxt.rdData = s_r.cmpP[7:0];
      end else if (busReq.addr == `PDT_OFF_PH) begin
        // P high byte
        s_nxt.rdData = s_r.cmpP[15:8];
      end else begin
        // Unmapped reads zero
        s_nxt.rdData = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset clears every field at once
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from flops
  // ----------------------------------------------------------------
  // No logic between these flops and the pins
  assign rdData                 = s_r.rdData;
  assign timerOutputPin         = s_r.outPin;
  assign timerOutputInvertedPin = s_r.outPinN;
  assign matchAEvt              = s_r.evtA;
  assign matchPEvt              = s_r.evtP;

endmodule

// *** pdt_pin_model.sv ***
// ----------------------------------------------------------------
// Far-side pins: external clock, capture input, foreign clocks
// ----------------------------------------------------------------
module pdt_pin_model (
  output pdt_pkg::pdt_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ps;
  import pdt_pkg::*;

  logic extLvl = 1'b0;  // External clock, idle low between bursts
  logic capLvl = 1'b0;  // Capture input level
  logic hsLvl  = 1'b0;  // Fast internal clock, runs free
  logic lsLvl  = 1'b0;  // Slow internal clock, runs free

  // Foreign clocks on the mclk grid, edges always on mclk falling edges
  always #40 hsLvl = ~hsLvl;
  always #60 lsLvl = ~lsLvl;

  // Pins are only ever inputs to the timer
  assign pins = '{lsClk: lsLvl, hsClk: hsLvl, capIn: capLvl, extClk: extLvl};

  // Burst of full pulses, each level held well past the sync delay
  task automatic ext_pulses(input int n);
    // Step off the clock edge the caller returned on
    #3;
    repeat (n) begin
      extLvl = 1'b1;
      #83;
      extLvl = 1'b0;
      #83;
    end
  endtask

  // Capture input level change
  task automatic set_cap(input logic lvl);
    #3;
    capLvl = lvl;
  endtask
endmodule

// *** pdt_timer_monitor.sv ***
`include "pdt_params.svh"

// ----------------------------------------------------------------
// Port checker for the timer
// ----------------------------------------------------------------
module pdt_timer_monitor (
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire pdt_pkg::pdt_bus_req_t busReq,
  input wire logic [7:0]            rdData,
  input wire pdt_pkg::pdt_pins_t    pinsIn,
  input wire logic                  timerOutputPin,
  input wire logic                  timerOutputInvertedPin,
  input wire logic                  matchAEvt,
  input wire logic                  matchPEvt
);
  timeunit 1ns;
  timeprecision 1ps;
  import pdt_pkg::*;

  logic [7:0] c0Sh_r;  // Software view of control 0
  logic [7:0] c1Sh_r;  // Software view of control 1
  logic [7:0] c2Sh_r;  // Software view of capture control
  logic [3:0] age_r;   // Cycles since last control 0 or control 1 write

  // Track control writes so checks know the configuration
  always_ff @(posedge mclk) begin
    if (reset) begin
      c0Sh_r <= 8'h00;
      c1Sh_r <= 8'h00;
      c2Sh_r <= 8'h00;
      age_r  <= 4'h0;
    end else begin
      if (busReq.wr && busReq.addr == `PDT_OFF_C0) c0Sh_r <= busReq.wdata & `PDT_MASK_C0;
      if (busReq.wr && busReq.addr == `PDT_OFF_C1) c1Sh_r <= busReq.wdata;
      if (busReq.wr && busReq.addr == `PDT_OFF_C2) c2Sh_r <= busReq.wdata & `PDT_MASK_C2;
      if (busReq.wr && busReq.addr <= `PDT_OFF_C1) age_r <= 4'h0;
      else if (age_r != 4'hf) age_r <= age_r + 4'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // Timer switched on from off in compare mode
  sequence s_on_rise;
    busReq.wr && busReq.addr == `PDT_OFF_C0 && busReq.wdata[3] && !c0Sh_r[3] &&
      c1Sh_r[7:6] == 2'b00;
  endsequence
  // Read request followed by its answer cycle
  sequence s_rd_at(logic [3:0] a);
    busReq.rd && busReq.addr == a ##1 1'b1;
  endsequence
  property p_one_cycle(logic e);
    e |=> !e;
  endproperty

  a_rd_idle_zero: assert property (!$past(busReq.rd) |-> rdData == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_c0_readback: assert property (s_rd_at(`PDT_OFF_C0) |-> rdData == $past(c0Sh_r))
    else $error("control 0 read back wrong");
  a_c2_readback: assert property (s_rd_at(`PDT_OFF_C2) |-> rdData[7:1] == $past(c2Sh_r[7:1]))
    else $error("capture control read back wrong");
  a_unmapped_zero: assert property (busReq.rd && busReq.addr > `PDT_OFF_PH |=> rdData == 8'h00)
    else $error("unmapped read not zero");
  a_evt_a_pulse: assert property (p_one_cycle(matchAEvt))
    else $error("match A event longer than one cycle");
  a_evt_p_pulse: assert property (p_one_cycle(matchPEvt))
    else $error("match P event longer than one cycle");
  a_no_p_clr: assert property (c1Sh_r[0] && c1Sh_r[6] == c1Sh_r[7] && age_r >= 4'h2
    |-> !matchPEvt) else $error("match P event with A clear selected");
  a_cmp_set: assert property (matchAEvt && c1Sh_r[7:6] == 2'b00 && (c1Sh_r[5] ^ c1Sh_r[4]) &&
    age_r >= 4'h2 |-> ##[0:3] timerOutputPin == (c1Sh_r[5] ^ c1Sh_r[2]))
    else $error("compare output level wrong after match");
  a_on_rise_init: assert property (s_on_rise |-> ##[1:3] timerOutputPin == (c1Sh_r[3] ^ c1Sh_r[2]))
    else $error("output not at initial level after switch on");
  a_pwm_force: assert property (c1Sh_r[7:6] == 2'b10 && !c1Sh_r[5] && c0Sh_r[3] && age_r >= 4'h4
    |-> timerOutputPin == ((c1Sh_r[4] ~^ c1Sh_r[3]) ^ c1Sh_r[2]))
    else $error("forced output level wrong");
endmodule

bind pdt_timer pdt_timer_monitor MON (.mclk(mclk), .reset(reset), .busReq(busReq), .rdData(rdData),
  .pinsIn(pinsIn), .timerOutputPin(timerOutputPin),
  .timerOutputInvertedPin(timerOutputInvertedPin), .matchAEvt(matchAEvt), .matchPEvt(matchPEvt));

// *** tb_pdt_timer.sv ***
`include "pdt_params.svh"

module tb_pdt_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import pdt_pkg::*;

  logic         mclk    = 1'b0;  // 50 MHz clock
  logic         reset   = 1'b1;  // Synchronous reset
  pdt_bus_req_t busReq  = '0;    // Register port request
  pdt_pins_t    pinsIn;          // Pins from the far-side model
  logic [7:0]   rdData;          // Read answer
  logic         outPin;          // Timer output
  logic         outPinN;         // Inverted companion output
  logic         evA;             // Match A event
  logic         evP;             // Match P event
  logic [8:0]   expQ[$];         // Expected reads, bit 8 means any nonzero
  logic [8:0]   e;               // Note under comparison
  logic         rdPrev  = 1'b0;  // Read strobe one cycle back
  logic [7:0]   v;               // Random byte
  logic         oc;              // Chosen initial level
  logic         pol;             // Chosen inversion
  logic         lvl;             // Expected level before inversion
  integer       seed    = 32'h8721;
  int           bad_count = 0;
  int           checks    = 0;
  int           nA = 0;
  int           nP = 0;
  int           n0;

  always #10 mclk = ~mclk;

  pdt_timer DUT (.mclk(mclk), .reset(reset), .busReq(busReq), .rdData(rdData), .pinsIn(pinsIn),
    .timerOutputPin(outPin), .timerOutputInvertedPin(outPinN), .matchAEvt(evA), .matchPEvt(evP));
  pdt_pin_model PIN (.pins(pinsIn));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    busReq.addr  <= a;
    busReq.wdata <= d;
    busReq.wr    <= 1'b1;
    @(posedge mclk);
    busReq.wr <= 1'b0;
  endtask

  // Write data carries noise during reads; the port must ignore it
  task automatic rd(input logic [3:0] a, input logic [8:0] x);
    logic [31:0] r;
    r = $random(seed);
    expQ.push_back(x);
    @(posedge mclk);
    busReq.addr  <= a;
    busReq.wdata <= r[7:0];
    busReq.rd    <= 1'b1;
    @(posedge mclk);
    busReq.rd <= 1'b0;
  endtask

  // Off, new mode, then on so the counter starts from zero
  task automatic restart(input logic [7:0] c1);
    wr(`PDT_OFF_C0, 8'h60);
    wr(`PDT_OFF_C1, c1);
    wr(`PDT_OFF_C0, 8'h68);
  endtask

  // Answer watcher: oldest note against the answer cycle
  always @(posedge mclk) begin
    rdPrev <= busReq.rd;
    if (evA === 1'b1) nA++;
    if (evP === 1'b1) nP++;
    if (rdPrev) begin
      if (expQ.size() == 0) chk(1'b0, "read answer without request");
      else begin
        e = expQ.pop_front();
        chk(e[8] ? (rdData !== 8'h00) : (rdData === e[7:0]), "read data mismatch");
      end
    end
  end

  // Hang guard
  initial begin
    #1900000;
    chk(1'b0, "run did not finish");
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    for (int a = 0; a <= 10; a++) rd(a[3:0], 9'h000);
    rd(4'hf, 9'h000);
    wr(`PDT_OFF_C0, 8'hff);
    rd(`PDT_OFF_C0, 9'h0f8);
    wr(`PDT_OFF_C0, 8'h00);
    wr(`PDT_OFF_C2, 8'hff);
    rd(`PDT_OFF_C2, 9'h006);
    wr(`PDT_OFF_C2, 8'h00);
    for (int a = 5; a <= 10; a++) begin
      v = 8'($random(seed));
      wr(a[3:0], v);
      rd(a[3:0], {1'b0, v});
      wr(a[3:0], 8'h00);
    end
    wr(`PDT_OFF_DL, 8'hff);
    wr(`PDT_OFF_DH, 8'hff);
    rd(`PDT_OFF_DL, 9'h000);
    rd(`PDT_OFF_DH, 9'h000);
    // Every internal clock source makes the counter advance
    for (int c = 0; c < 6; c++) begin
      wr(`PDT_OFF_C0, {1'b0, c[2:0], 4'h8});
      tick(600);
      wr(`PDT_OFF_C0, {1'b0, c[2:0], 4'h0});
      rd(`PDT_OFF_DL, 9'h100);
    end
    // Full 16-bit run wraps once and flags it
    n0 = nP;
    wr(`PDT_OFF_C0, 8'h18);
    tick(65545);
    wr(`PDT_OFF_C0, 8'h10);
    chk(nP == n0 + 1, "overflow event count");
    rd(`PDT_OFF_DH, 9'h000);
    // Pin edges, pause, off and restart
    wr(`PDT_OFF_C0, 8'h68);
    rd(`PDT_OFF_DL, 9'h000);
    PIN.ext_pulses(5);
    tick(8);
    rd(`PDT_OFF_DL, 9'h005);
    wr(`PDT_OFF_C0, 8'he8);
    PIN.ext_pulses(3);
    tick(8);
    rd(`PDT_OFF_DL, 9'h005);
    wr(`PDT_OFF_C0, 8'h68);
    PIN.ext_pulses(2);
    tick(8);
    rd(`PDT_OFF_DL, 9'h007);
    wr(`PDT_OFF_C0, 8'h60);
    PIN.ext_pulses(2);
    tick(8);
    rd(`PDT_OFF_DL, 9'h007);
    wr(`PDT_OFF_C0, 8'h78);
    PIN.ext_pulses(3);
    tick(8);
    rd(`PDT_OFF_DL, 9'h003);
    // Period clear by P, then clear by A
    wr(`PDT_OFF_PL, 8'h03);
    restart(8'h00);
    n0 = nP;
    PIN.ext_pulses(4);
    tick(8);
    rd(`PDT_OFF_DL, 9'h000);
    chk(nP == n0 + 1, "P clear event count");
    wr(`PDT_OFF_AL, 8'h02);
    restart(8'h01);
    n0 = nA;
    PIN.ext_pulses(3);
    tick(8);
    rd(`PDT_OFF_DL, 9'h000);
    chk(nA == n0 + 1, "A clear event count");
    // Compare output reactions, A clears the period
    v = 8'($random(seed));
    oc = v[0];
    pol = v[1];
    for (int io = 0; io < 4; io++) begin
      restart({2'b00, io[1:0], oc, pol, 2'b01});
      tick(6);
      chk(outPin === (oc ^ pol), "initial level");
      chk(outPinN === ~outPin, "companion output");
      PIN.ext_pulses(3);
      tick(8);
      lvl = (io == 1) ? 1'b0 : (io == 2) ? 1'b1 : (io == 3) ? ~oc : oc;
      chk(outPin === (lvl ^ pol), "compare reaction");
    end
    // Output modes: inactive, active, waveform, single pulse
    for (int io = 0; io < 4; io++) begin
      restart({2'b10, io[1:0], oc, pol, 2'b00});
      tick(6);
      chk(outPin === ((io != 0 ? oc : ~oc) ^ pol), "output before match");
      PIN.ext_pulses(3);
      tick(8);
      chk(outPin === ((io == 1 ? oc : ~oc) ^ pol), "output after match");
    end
    // Capture of the counter into A on a rising input
    wr(`PDT_OFF_PL, 8'h00);
    restart(8'h40);
    PIN.ext_pulses(4);
    tick(4);
    PIN.set_cap(1'b1);
    tick(8);
    rd(`PDT_OFF_AL, 9'h004);
    rd(`PDT_OFF_AH, 9'h000);
    PIN.set_cap(1'b0);
    // Edge clear: rise latches into B, sets the flag, clears the count
    wr(`PDT_OFF_C2, 8'h02);
    restart(8'h40);
    PIN.ext_pulses(3);
    tick(4);
    PIN.set_cap(1'b1);
    tick(8);
    rd(`PDT_OFF_BL, 9'h003);
    rd(`PDT_OFF_C2, 9'h003);
    rd(`PDT_OFF_DL, 9'h000);
    PIN.set_cap(1'b0);
    wr(`PDT_OFF_C2, 8'h00);
    // Plain timer mode still counts, output left alone
    restart(8'hc0);
    PIN.ext_pulses(2);
    tick(8);
    rd(`PDT_OFF_DL, 9'h002);
    tick(4);
    chk(expQ.size() == 0, "reads left unanswered");
    stop_test();
  end
endmodule
